// ===== hsw_defs.vh
`ifndef HSW_DEFS_VH
`define HSW_DEFS_VH

// register byte addresses
`define HSW_A_FRAME   12'h000
`define HSW_A_STATE   12'h004
`define HSW_A_CLEAR   12'h00C
`define HSW_A_DW4     12'h010
`define HSW_A_DW5     12'h014
`define HSW_A_DW6     12'h018
`define HSW_A_DW7     12'h01C

// widths
`define HSW_AW        12
`define HSW_DW        32
`define HSW_NUF       8
`define HSW_CNTW      12
`define HSW_OCW       3
`define HSW_FRW       5
`define HSW_UFW       3

// outcome code bit positions
`define HSW_OC_XERR   0
`define HSW_OC_BABL   1
`define HSW_OC_UNDR   2

// fifo entry layout
`define HSW_E_W       23
`define HSW_E_OC_LO   0
`define HSW_E_OC_HI   2
`define HSW_E_CNT_LO  3
`define HSW_E_CNT_HI  14
`define HSW_E_FR_LO   15
`define HSW_E_FR_HI   19
`define HSW_E_UF_LO   20
`define HSW_E_UF_HI   22

`define HSW_FIFO_D    8
`define HSW_FIFO_AW   3
`define HSW_FIFO_CW   4

// reset values
`define HSW_RST_MASK  8'h00
`define HSW_RST_FRAME 5'h00
`define HSW_RST_CNT   12'h000
`define HSW_RST_OC    3'h0
`define HSW_RST_WORD  32'h00000000
`define HSW_RST_TOT   16'h0000

`endif

// ===== hsw_endpoint_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsw_defs.vh"
module hsw_endpoint_model (
   input  wire logic                 ref_clk_in,
   input  wire logic                 res_ready_in,
   output var  logic                 res_valid_out = 1'b0,
   output var  logic [`HSW_UFW-1:0]  res_uframe_out = '0,
   output var  logic [`HSW_FRW-1:0]  res_frame_out = '0,
   output var  logic [`HSW_CNTW-1:0] res_count_out = '0,
   output var  logic                 res_is_in_out = 1'b0,
   output var  logic                 res_xact_err_out = 1'b0,
   output var  logic                 res_babble_out = 1'b0,
   output var  logic                 res_underrun_out = 1'b0
);
   // fl is {is_in, xact_err, babble, underrun}; gap delays the offer to act slow
   task automatic send(input logic [2:0] uf, input logic [4:0] fr, input logic [11:0] cnt,
                       input logic [3:0] fl, input int gap);
      int k;
      repeat (gap) @(posedge ref_clk_in);
      res_valid_out <= 1'b1;
      res_uframe_out <= uf;
      res_frame_out <= fr;
      res_count_out <= cnt;
      {res_is_in_out, res_xact_err_out, res_babble_out, res_underrun_out} <= fl;
      k = 0;
      do begin
         @(posedge ref_clk_in);
         k++;
      end while (res_ready_in !== 1'b1 && k < 50);
      // an engine that never gets taken is a hang, so it ends the run as a failure
      if (res_ready_in !== 1'b1) begin
         hsw_writeback_tb.failures++;
         hsw_writeback_tb.summarize();
      end
      // released lines carry the inverse so a stale value never passes for a fresh one
      res_valid_out <= 1'b0;
      res_uframe_out <= ~uf;
      res_frame_out <= ~fr;
      res_count_out <= ~cnt;
      {res_is_in_out, res_xact_err_out, res_babble_out, res_underrun_out} <= ~fl;
      @(posedge ref_clk_in);
   endtask
endmodule // hsw_endpoint_model
`default_nettype wire

// ===== hsw_fifo.v
`timescale 1ns/1ps
`default_nettype none
`include "hsw_defs.vh"

module hsw_fifo #(
   parameter WIDTH = `HSW_E_W,
   parameter DEPTH = `HSW_FIFO_D,
   parameter AW    = `HSW_FIFO_AW,
   parameter CW    = `HSW_FIFO_CW
) (
   input  wire             ref_clk_in,
   input  wire             rst_in,
   input  wire             in_valid_in,
   output reg              in_ready_out,
   input  wire [WIDTH-1:0] in_data_in,
   output reg              out_valid_out,
   input  wire             out_ready_in,
   output wire [WIDTH-1:0] out_data_out,
   output reg  [CW-1:0]    level_out
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_r;
   reg [AW-1:0]    rd_ptr_r;
   wire            push;
   wire            pop;
   wire [CW-1:0]   level_nxt;

   assign push = in_valid_in & in_ready_out;
   assign pop  = out_valid_out & out_ready_in;
   assign level_nxt = level_out + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop};
   assign out_data_out = mem_r[rd_ptr_r];

   always @(posedge ref_clk_in) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_in;
      end
   end

   // full and empty come from the registered level, so both flags are honest
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         wr_ptr_r      <= {AW{1'b0}};
         rd_ptr_r      <= {AW{1'b0}};
         level_out     <= {CW{1'b0}};
         in_ready_out  <= 1'b0;
         out_valid_out <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
         end
         level_out     <= level_nxt;
         in_ready_out  <= (level_nxt != DEPTH);
         out_valid_out <= (level_nxt != {CW{1'b0}});
      end
   end
endmodule // hsw_fifo

`default_nettype wire

// ===== hsw_writeback.v
// Contract
// RL1: uframe 7 count to DW7 bits 63..52
// RL2: uframe 6 count to DW7 bits 51..40
// RL3: uframe 5 count split DW7 39..32, DW6 31..28
// RL4: uframe 5 low nibble tops DW6
// RL5: uframe 4 count to DW6 bits 27..16
// RL6: uframe 3 count to DW6 bits 15..4
// RL7: uframe 2 count high nibble DW6 3..0
// RL8: uframe 2 count low byte DW5 63..56
// RL9: uframe 1 count to DW5 bits 55..44
// RL10: uframe 0 count to DW5 bits 43..32
// RL11: uframe 7 outcome to DW4 31..29
// RL12: uframe 6 outcome to DW4 28..26
// RL13: uframe 5 outcome to DW4 25..23
// RL14: outcome bits: error, babble in, underrun out
// RL15: software sets mask, hardware clears after service
// RL16: uframes 4..0 outcomes fill DW4 22..8
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "hsw_defs.vh"

module hsw_writeback (
   input  wire                   ref_clk_in,
   input  wire                   rst_in,
   // apb slave
   input  wire                   psel_in,
   input  wire                   penable_in,
   input  wire                   pwrite_in,
   input  wire [`HSW_AW-1:0]     paddr_in,
   input  wire [`HSW_DW-1:0]     pwdata_in,
   output reg  [`HSW_DW-1:0]     prdata_out,
   output reg                    pready_out,
   output reg                    pslverr_out,
   // result stream from the isochronous endpoint engine
   input  wire                   res_valid_in,
   output wire                   res_ready_out,
   input  wire [`HSW_UFW-1:0]    res_uframe_in,
   input  wire [`HSW_FRW-1:0]    res_frame_in,
   input  wire [`HSW_CNTW-1:0]   res_count_in,
   input  wire                   res_is_in_in,
   input  wire                   res_xact_err_in,
   input  wire                   res_babble_in,
   input  wire                   res_underrun_in,
   // retire strobe
   output reg                    wb_done_out,
   output reg  [`HSW_UFW-1:0]    wb_uframe_out,
   output reg                    wb_hit_out
);

   // outcome code assembled at the input, so the fifo carries finished codes
   reg  [`HSW_OCW-1:0]    in_code;
   wire [`HSW_E_W-1:0]    in_entry;

   always @* begin
      in_code = `HSW_RST_OC;
      in_code[`HSW_OC_XERR] = res_xact_err_in;                  // see RL14
      in_code[`HSW_OC_BABL] = res_babble_in & res_is_in_in;     // see RL14
      in_code[`HSW_OC_UNDR] = res_underrun_in & ~res_is_in_in;  // see RL14
   end

   assign in_entry = {res_uframe_in, res_frame_in, res_count_in, in_code};

   // fifo between the endpoint engine and the descriptor
   wire                   q_valid;
   wire                   q_ready;
   wire [`HSW_E_W-1:0]    q_data;
   wire [`HSW_FIFO_CW-1:0] q_level;

   // writeback pauses while software owns the bus, so the fifo really fills
   // and res_ready_out falls back to the engine
   assign q_ready = ~psel_in;

   hsw_fifo #(
      .WIDTH (`HSW_E_W),
      .DEPTH (`HSW_FIFO_D),
      .AW    (`HSW_FIFO_AW),
      .CW    (`HSW_FIFO_CW)
   ) u_fifo (
      .ref_clk_in    (ref_clk_in),
      .rst_in        (rst_in),
      .in_valid_in   (res_valid_in),
      .in_ready_out  (res_ready_out),
      .in_data_in    (in_entry),
      .out_valid_out (q_valid),
      .out_ready_in  (q_ready),
      .out_data_out  (q_data),
      .level_out     (q_level)
   );

   wire [`HSW_UFW-1:0]  q_uf;
   wire [`HSW_FRW-1:0]  q_fr;
   wire [`HSW_CNTW-1:0] q_cnt;
   wire [`HSW_OCW-1:0]  q_oc;
   wire                 q_pop;

   assign q_uf  = q_data[`HSW_E_UF_HI:`HSW_E_UF_LO];
   assign q_fr  = q_data[`HSW_E_FR_HI:`HSW_E_FR_LO];
   assign q_cnt = q_data[`HSW_E_CNT_HI:`HSW_E_CNT_LO];
   assign q_oc  = q_data[`HSW_E_OC_HI:`HSW_E_OC_LO];
   assign q_pop = q_valid & q_ready;

   // software registers
   reg [`HSW_FRW-1:0] frame_r;
   reg [`HSW_NUF-1:0] mask_r;
   reg [`HSW_NUF-1:0] mask_nxt;
   reg [15:0]         hit_tot_r;
   reg [15:0]         miss_tot_r;

   wire               apb_acc;
   wire               apb_wr;
   wire               apb_rd;
   wire               frame_hit;
   wire               uf_live;
   wire               wb_go;
   wire [`HSW_NUF-1:0] sw_set;
   wire [`HSW_NUF-1:0] sw_clr;
   wire [`HSW_NUF-1:0] hw_clr;

   assign apb_acc = psel_in & penable_in & pready_out;
   assign apb_wr  = apb_acc & pwrite_in;
   assign apb_rd  = psel_in & penable_in & ~pready_out & ~pwrite_in;

   assign frame_hit = (q_fr == frame_r);
   assign uf_live   = mask_r[q_uf];
   assign wb_go     = q_pop & frame_hit & uf_live;          // see RL15

   // software may only raise mask bits; zeros in the write leave them alone
   assign sw_set = (apb_wr && paddr_in == `HSW_A_DW4) ?
                   pwdata_in[`HSW_NUF-1:0] : {`HSW_NUF{1'b0}};
   assign sw_clr = (apb_wr && paddr_in == `HSW_A_CLEAR) ?
                   pwdata_in[`HSW_NUF-1:0] : {`HSW_NUF{1'b0}};

   // per-uframe result storage
   wire [`HSW_CNTW-1:0] cnt_w [0:`HSW_NUF-1];
   wire [`HSW_OCW-1:0]  oc_w  [0:`HSW_NUF-1];

   genvar g;
   generate
      for (g = 0; g < `HSW_NUF; g = g + 1) begin : g_uf
         reg [`HSW_CNTW-1:0] cnt_r;
         reg [`HSW_OCW-1:0]  oc_r;
         wire                hit;

         assign hit = wb_go && (q_uf == g);
         assign hw_clr[g] = hit;
         assign cnt_w[g] = cnt_r;
         assign oc_w[g]  = oc_r;

         // a fresh result wins over a software clear in the same cycle
         always @(posedge ref_clk_in) begin
            if (rst_in) begin
               cnt_r <= `HSW_RST_CNT;
               oc_r  <= `HSW_RST_OC;
            end else if (hit) begin
               cnt_r <= q_cnt;
               oc_r  <= q_oc;
            end else if (sw_clr[g]) begin
               cnt_r <= `HSW_RST_CNT;
               oc_r  <= `HSW_RST_OC;
            end
         end
      end
   endgenerate

   // hardware clear first, then software set, so a set in the same cycle wins
   always @* begin
      mask_nxt = (mask_r & ~hw_clr) | sw_set;               // see RL15
   end

   // descriptor words as software sees them, in 32-bit halves
   wire [`HSW_DW-1:0] dw7;
   wire [`HSW_DW-1:0] dw6;
   wire [`HSW_DW-1:0] dw5;
   wire [`HSW_DW-1:0] dw4;

   assign dw7 = {cnt_w[7],                                  // see RL1
                 cnt_w[6],                                  // see RL2
                 cnt_w[5][11:4]};                           // see RL3
   assign dw6 = {cnt_w[5][3:0],                             // see RL3 see RL4
                 cnt_w[4],                                  // see RL5
                 cnt_w[3],                                  // see RL6
                 cnt_w[2][11:8]};                           // see RL7
   assign dw5 = {cnt_w[2][7:0],                             // see RL8
                 cnt_w[1],                                  // see RL9
                 cnt_w[0]};                                 // see RL10
   assign dw4 = {oc_w[7],                                   // see RL11
                 oc_w[6],                                   // see RL12
                 oc_w[5],                                   // see RL13
                 oc_w[4], oc_w[3], oc_w[2], oc_w[1], oc_w[0], // see RL16
                 mask_r};                                   // see RL15

   // control registers
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         frame_r <= `HSW_RST_FRAME;
         mask_r  <= `HSW_RST_MASK;
      end else begin
         mask_r <= mask_nxt;
         if (apb_wr && paddr_in == `HSW_A_FRAME) begin
            frame_r <= pwdata_in[`HSW_FRW-1:0];
         end
      end
   end

   // retire strobe and tallies; a result for a stale frame or an idle
   // uframe is dropped without touching the descriptor
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         wb_done_out   <= 1'b0;
         wb_uframe_out <= {`HSW_UFW{1'b0}};
         wb_hit_out    <= 1'b0;
         hit_tot_r     <= `HSW_RST_TOT;
         miss_tot_r    <= `HSW_RST_TOT;
      end else begin
         wb_done_out <= q_pop;
         wb_hit_out  <= wb_go;
         if (q_pop) begin
            wb_uframe_out <= q_uf;
         end
         if (wb_go) begin
            hit_tot_r <= hit_tot_r + 16'h0001;
         end else if (q_pop) begin
            miss_tot_r <= miss_tot_r + 16'h0001;
         end
      end
   end

   // apb: one wait state, so pready rises on the second access cycle
   reg [`HSW_DW-1:0] rd_mux;
   reg               rd_bad;

   always @* begin
      rd_mux = `HSW_RST_WORD;
      rd_bad = 1'b0;
      case (paddr_in)
         `HSW_A_FRAME: rd_mux = {{(`HSW_DW-`HSW_FRW){1'b0}}, frame_r};
         `HSW_A_STATE: rd_mux = {miss_tot_r[11:0], hit_tot_r[11:0],
                                 3'h0, q_valid, q_level};
         `HSW_A_CLEAR: rd_mux = `HSW_RST_WORD;
         `HSW_A_DW4:   rd_mux = dw4;
         `HSW_A_DW5:   rd_mux = dw5;
         `HSW_A_DW6:   rd_mux = dw6;
         `HSW_A_DW7:   rd_mux = dw7;
         default:      rd_bad = 1'b1;
      endcase
   end

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= `HSW_RST_WORD;
      end else begin
         pready_out  <= psel_in & penable_in & ~pready_out;
         pslverr_out <= psel_in & penable_in & ~pready_out & rd_bad;
         if (apb_rd) begin
            prdata_out <= rd_bad ? `HSW_RST_WORD : rd_mux;
         end
      end
   end

endmodule // hsw_writeback

`default_nettype wire

// ===== hsw_writeback_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsw_defs.vh"
module hsw_writeback_monitor (
   input wire logic               ref_clk_in,
   input wire logic               rst_in,
   input wire logic               psel_in,
   input wire logic               penable_in,
   input wire logic               pwrite_in,
   input wire logic [`HSW_DW-1:0] prdata_out,
   input wire logic               pready_out,
   input wire logic               pslverr_out,
   input wire logic               res_ready_out,
   input wire logic               wb_done_out,
   input wire logic               wb_hit_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   a_ready_one_cycle: assert property (pready_out |=> !pready_out)
      else $error("pready held too long");
   a_ready_after_access: assert property ($rose(penable_in) && psel_in |=> pready_out)
      else $error("pready late");
   a_ready_needs_access: assert property (pready_out |-> $past(psel_in) && $past(penable_in))
      else $error("pready without access");
   a_err_with_ready: assert property (pslverr_out |-> pready_out)
      else $error("pslverr without pready");
   a_unmapped_reads_zero: assert property (pslverr_out && !pwrite_in |-> prdata_out == '0)
      else $error("refused read data not zero");
   a_ready_after_reset: assert property ($fell(rst_in) |=> res_ready_out)
      else $error("result ready late after reset");
   a_no_drain_busy: assert property (psel_in |=> !wb_done_out)
      else $error("drain during bus activity");
   a_hit_needs_done: assert property (wb_hit_out |-> wb_done_out)
      else $error("hit without retire");
   c_write: cover property (psel_in && penable_in && pwrite_in && pready_out);
   c_hit: cover property (wb_hit_out);
   c_full: cover property (!res_ready_out);
   c_refused: cover property (pslverr_out);
endmodule // hsw_writeback_monitor
bind hsw_writeback hsw_writeback_monitor mon (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .res_ready_out(res_ready_out), .wb_done_out(wb_done_out), .wb_hit_out(wb_hit_out));
`default_nettype wire

// ===== hsw_writeback_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsw_defs.vh"
`define CHK(n, x, a) begin checks_done++; if ((a) !== (x)) begin failures++; \
   $display("mismatch %s expected %0h seen %0h", n, x, a); end end
module hsw_writeback_tb;
   logic                ref_clk_in = 1'b0;
   logic                rst_in = 1'b1;
   logic                psel_in = 1'b0;
   logic                penable_in = 1'b0;
   logic                pwrite_in = 1'b0;
   logic [`HSW_AW-1:0]  paddr_in = '0;
   logic [`HSW_DW-1:0]  pwdata_in = '0;
   logic [`HSW_DW-1:0]  prdata_out, rd;
   logic                pready_out, pslverr_out, er, rv, rr, ii, xe, bb, ur, done, hit;
   logic [2:0]          ruf, wuf;
   logic [4:0]          rfr;
   logic [11:0]         rcnt;
   logic [31:0]         ew [4];
   int                  failures = 0, checks_done = 0, n;
   // row: uframe, count, {is_in, err, babble, underrun}, expected outcome code
   logic [23:0]         rows [8] = '{24'h0001C1, 24'h17FFA2, 24'h2ABC14, 24'h312320,
                                     24'h4FFFB2, 24'h55A375, 24'h6800F3, 24'h70E700};
   hsw_endpoint_model ep (.ref_clk_in(ref_clk_in), .res_ready_in(rr), .res_valid_out(rv), .res_uframe_out(ruf),
      .res_frame_out(rfr), .res_count_out(rcnt), .res_is_in_out(ii), .res_xact_err_out(xe),
      .res_babble_out(bb), .res_underrun_out(ur));
   hsw_writeback dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .res_valid_in(rv), .res_ready_out(rr),
      .res_uframe_in(ruf), .res_frame_in(rfr), .res_count_in(rcnt), .res_is_in_in(ii),
      .res_xact_err_in(xe), .res_babble_in(bb), .res_underrun_in(ur), .wb_done_out(done),
      .wb_uframe_out(wuf), .wb_hit_out(hit));
   initial begin
      forever #25 ref_clk_in = ~ref_clk_in;
   end
   task automatic summarize();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // keep leaves psel up so the next call's setup follows at once
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic keep);
      int k;
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge ref_clk_in);
      penable_in <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk_in);
         k++;
      end while (pready_out !== 1'b1 && k < 20);
      if (k >= 20) begin
         failures++;
         summarize();
      end
      rd = prdata_out;
      er = pslverr_out;
      penable_in <= 1'b0;
      if (!keep) begin
         psel_in <= 1'b0;
         @(posedge ref_clk_in);
      end
   endtask
   task automatic wait_done();
      n = 0;
      do begin
         @(posedge ref_clk_in);
         n++;
      end while (done !== 1'b1 && n < 60);
      if (n >= 60) begin
         failures++;
         summarize();
      end
   endtask
   task automatic place(input logic [2:0] u, input logic [11:0] c);
      case (u)
         3'h0: ew[1][11:0] = c;
         3'h1: ew[1][23:12] = c;
         3'h2: begin
            ew[1][31:24] = c[7:0];
            ew[2][3:0] = c[11:8];
         end
         3'h3: ew[2][15:4] = c;
         3'h4: ew[2][27:16] = c;
         3'h5: begin
            ew[2][31:28] = c[3:0];
            ew[3][7:0] = c[11:4];
         end
         3'h6: ew[3][19:8] = c;
         default: ew[3][31:20] = c;
      endcase
   endtask
   task automatic check_words();
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, `HSW_A_DW4 + 12'(4 * i), 32'h0, 1'b0);
         `CHK("desc_word", ew[i], rd)
      end
   endtask
   initial begin
      #4000000;
      failures++;
      summarize();
   end
   initial begin
      ew = '{32'h0, 32'h0, 32'h0, 32'h0};
      repeat (12) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      check_words();
      apb(1'b1, `HSW_A_FRAME, 32'h00000015, 1'b0);
      apb(1'b0, `HSW_A_FRAME, 32'h0, 1'b0);
      `CHK("frame", 32'h00000015, rd)
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, `HSW_A_DW4, 32'h1 << rows[i][22:20], 1'b0);
         ep.send(rows[i][22:20], 5'h15, rows[i][19:8], rows[i][7:4], i);
         wait_done();
         `CHK("hit", 1'b1, hit)
         `CHK("uframe", rows[i][22:20], wuf)
         place(rows[i][22:20], rows[i][19:8]);
         ew[0][8 + 3 * rows[i][22:20] +: 3] = rows[i][2:0];
         check_words();
      end
      // wrong frame, then a matching frame whose mask bit is clear
      apb(1'b1, `HSW_A_DW4, 32'h00000008, 1'b0);
      ew[0][3] = 1'b1;
      ep.send(3'h3, 5'h0A, 12'h555, 4'hF, 0);
      wait_done();
      `CHK("miss_frame", 1'b0, hit)
      ep.send(3'h5, 5'h15, 12'h666, 4'hF, 0);
      wait_done();
      `CHK("miss_mask", 1'b0, hit)
      apb(1'b0, 12'h008, 32'h0, 1'b0);
      `CHK("slverr", 1'b1, er)
      `CHK("refused_data", 32'h0, rd)
      apb(1'b1, `HSW_A_DW5, 32'hFFFFFFFF, 1'b0);
      check_words();
      // bus kept busy so nothing drains while the endpoint fills the fifo
      fork
         begin
            repeat (7) apb(1'b0, `HSW_A_STATE, 32'h0, 1'b1);
            apb(1'b0, `HSW_A_STATE, 32'h0, 1'b0);
         end
         begin
            for (int j = 0; j < 8; j++) ep.send(3'h0, 5'h01, 12'h000, 4'h0, 0);
            `CHK("fifo_full", 1'b0, rr)
         end
      join
      n = 0;
      repeat (30) begin
         @(posedge ref_clk_in);
         if (done === 1'b1) n++;
      end
      `CHK("drained", 8, n)
      apb(1'b0, `HSW_A_STATE, 32'h0, 1'b0);
      `CHK("tally", 24'h00A008, rd[31:8])
      `CHK("level", 5'h00, rd[4:0])
      // software clear of the upper four uframes leaves the rest alone
      apb(1'b1, `HSW_A_CLEAR, 32'h000000F0, 1'b0);
      for (int u = 4; u < 8; u++) begin
         place(3'(u), 12'h000);
         ew[0][8 + 3 * u +: 3] = 3'h0;
      end
      check_words();
      rst_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      ew = '{32'h0, 32'h0, 32'h0, 32'h0};
      check_words();
      summarize();
   end
endmodule // hsw_writeback_tb
`default_nettype wire
